// *** design/srctl_pkg.sv ***
package srctl_pkg;
    // Oscillation stabilization select codes.
    localparam logic [2:0] SRCTL_STAB_2E12 = 3'h0;
    localparam logic [2:0] SRCTL_STAB_2E15 = 3'h2;
    localparam logic [2:0] SRCTL_STAB_2E17 = 3'h4;
    // Select value after reset.
    localparam logic [2:0] SRCTL_STAB_RST = 3'h4;
    // Wait lengths in main-clock periods.
    localparam int SRCTL_WAIT_2E12 = 4096;
    localparam int SRCTL_WAIT_2E15 = 32768;
    localparam int SRCTL_WAIT_2E17 = 131072;
    // Reset-release wait length.
    localparam int SRCTL_WAIT_RST = 32768;
    // Stabilization counter width.
    localparam int SRCTL_CNT_W = 18;
    // Reset vector locations.
    localparam logic [15:0] SRCTL_VEC_LO = 16'h0000;
    localparam logic [15:0] SRCTL_VEC_HI = 16'h0001;
    // Minimum external reset pulse, and its cycle count at 200 MHz.
    localparam int SRCTL_RST_MIN_NS = 10000;
    localparam int SRCTL_CLK_NS = 5;
    localparam int SRCTL_RST_MIN_CYC = (SRCTL_RST_MIN_NS + SRCTL_CLK_NS - 1)
                                       / SRCTL_CLK_NS;
    // Resume delays after halt release, in clocks.
    localparam int SRCTL_RESUME_VEC = 9;
    localparam int SRCTL_RESUME_NEXT = 1;

    // Operating state.
    typedef enum logic [4:0] {
        SRCTL_RESET = 5'b00001,
        SRCTL_WAIT  = 5'b00010,
        SRCTL_RUN   = 5'b00100,
        SRCTL_HALT  = 5'b01000,
        SRCTL_STOP  = 5'b10000
    } srctl_state_t;
endpackage

// *** design/srctl_sync.sv ***
`timescale 1ns/100ps
// Three-flop synchroniser; output changes once stages two and three agree.
module srctl_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] sh_r;

    // Shift register of the asynchronous level.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_r <= {3{RST_VAL}};
        end else begin
            sh_r <= {sh_r[1:0], din};
        end
    end

    // Filtered level follows only agreeing stages.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dout <= RST_VAL;
        end else if (sh_r[1] == sh_r[2]) begin
            dout <= sh_r[2];
        end
    end
endmodule // srctl_sync

// *** design/srctl_top.sv ***
`timescale 1ns/100ps
module srctl_top
    import srctl_pkg::*;
#(
    parameter int N_IRQ    = 8,
    parameter int WAIT_RST = srctl_pkg::SRCTL_WAIT_RST,
    parameter int WAIT_12  = srctl_pkg::SRCTL_WAIT_2E12,
    parameter int WAIT_15  = srctl_pkg::SRCTL_WAIT_2E15,
    parameter int WAIT_17  = srctl_pkg::SRCTL_WAIT_2E17
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             reset_pin_b,
    input  wire logic             wdt_overflow,
    input  wire logic             halt_instr,
    input  wire logic             stop_instr,
    input  wire logic [N_IRQ-1:0] irq_request_flag,
    input  wire logic [N_IRQ-1:0] interrupt_mask_flag,
    input  wire logic             nmi_request,
    input  wire logic             global_interrupt_enable,
    input  wire logic [2:0]       stab_time_select,
    input  wire logic             count_input_a_sel,
    input  wire logic             count_input_b_sel,
    input  wire logic             subclk_selected,
    input  wire logic             subclk_running,
    input  wire logic             buzzer_enable,
    input  wire logic             serial_ext_clk,
    input  wire logic             bus_slave_mode,
    output logic                  core_reset,
    output logic                  core_run,
    output logic                  main_osc_enable,
    output logic                  pins_hiz,
    output logic                  port_latch_hold,
    output logic                  dispatch_vector,
    output logic                  dispatch_next,
    output logic                  load_reset_vector,
    output logic [15:0]           reset_vector_lo_addr,
    output logic [15:0]           reset_vector_hi_addr,
    output logic                  wdt_enable,
    output logic                  adc_enable,
    output logic                  mul_enable,
    output logic                  ext_irq_enable,
    output logic                  event_counter_a_enable,
    output logic                  event_counter_b_enable,
    output logic                  sixteen_bit_timer_enable,
    output logic                  eight_bit_timer_c_enable,
    output logic                  watch_timer_enable,
    output logic                  serial_enable,
    output logic                  bus_addr_irq_enable,
    output logic                  stab_select_bad,
    output logic [2:0]            state_code
);
    import srctl_pkg::*;

    // Refuse wait lengths that the stabilization counter cannot hold.
    localparam int CNT_SPAN = 1 << SRCTL_CNT_W;
    if (N_IRQ < 1 || WAIT_RST < 1 || WAIT_12 < 1 || WAIT_15 < 1 ||
        WAIT_17 < 1 || WAIT_RST > CNT_SPAN || WAIT_12 > CNT_SPAN ||
        WAIT_15 > CNT_SPAN || WAIT_17 > CNT_SPAN) begin : g_bad_params
        $error("srctl_top: unsupported parameter values");
    end

    // ======================================================
    // Reset sources
    // ======================================================
    logic pin_b_s;
    logic rst_req;

    srctl_sync #(.RST_VAL(1'b0)) u_pin_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (reset_pin_b),
        .dout  (pin_b_s)
    );

    // Either source requests the same reset.
    assign rst_req = !pin_b_s || wdt_overflow;

    // ======================================================
    // Wake request and stabilization length
    // ======================================================
    logic                   wake_req;
    logic [SRCTL_CNT_W-1:0] sel_len;
    logic                   sel_bad;

    // Wake request is OR of unmasked request flags.
    assign wake_req = |(irq_request_flag & ~interrupt_mask_flag);

    // Decode the select field into a wait length.
    always_comb begin
        sel_bad = 1'b0;
        unique case (stab_time_select)
            SRCTL_STAB_2E12: sel_len = SRCTL_CNT_W'(WAIT_12 - 1);
            SRCTL_STAB_2E15: sel_len = SRCTL_CNT_W'(WAIT_15 - 1);
            SRCTL_STAB_2E17: sel_len = SRCTL_CNT_W'(WAIT_17 - 1);
            default: begin
                sel_len = SRCTL_CNT_W'(WAIT_17 - 1);
                sel_bad = 1'b1;
            end
        endcase
    end

    // ======================================================
    // Sequencer
    // ======================================================
    srctl_state_t           state_r;
    logic [SRCTL_CNT_W-1:0] cnt_r;
    logic [SRCTL_CNT_W-1:0] limit_r;
    logic                   wait_is_reset_r;
    logic [3:0]             resume_r;
    logic                   resume_vec_r;
    logic                   cnt_done;

    assign cnt_done = (cnt_r == limit_r);

    // State transitions.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= SRCTL_RESET;
        end else if (rst_req) begin
            state_r <= SRCTL_RESET;
        end else begin
            unique case (state_r)
                SRCTL_RESET: state_r <= SRCTL_WAIT;
                SRCTL_WAIT: begin
                    if (cnt_done) begin
                        state_r <= SRCTL_RUN;
                    end
                end
                SRCTL_RUN: begin
                    if (stop_instr) begin
                        // Pending request: pass stop, then wait.
                        state_r <= wake_req ? SRCTL_WAIT
                                            : SRCTL_STOP;
                    end else if (halt_instr && resume_r == 4'h0) begin
                        state_r <= SRCTL_HALT;
                    end
                end
                SRCTL_HALT: begin
                    if (wake_req || nmi_request) begin
                        state_r <= SRCTL_RUN;
                    end
                end
                SRCTL_STOP: begin
                    if (wake_req) begin
                        state_r <= SRCTL_WAIT;
                    end
                end
            endcase
        end
    end

    // Stabilization counter, restarted at each release event.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r           <= '0;
            limit_r         <= SRCTL_CNT_W'(WAIT_RST - 1);
            wait_is_reset_r <= 1'b1;
        end else if (rst_req || state_r == SRCTL_RESET) begin
            cnt_r           <= '0;
            limit_r         <= SRCTL_CNT_W'(WAIT_RST - 1);
            wait_is_reset_r <= 1'b1;
        end else if (state_r == SRCTL_WAIT) begin
            if (!cnt_done) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end else begin
            cnt_r           <= '0;
            limit_r         <= sel_len;
            wait_is_reset_r <= 1'b0;
        end
    end

    // Resume delay after an interrupt release.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resume_r     <= 4'h0;
            resume_vec_r <= 1'b0;
        end else if (rst_req) begin
            resume_r     <= 4'h0;
            resume_vec_r <= 1'b0;
        end else if (state_r == SRCTL_HALT && (wake_req || nmi_request)) begin
            resume_vec_r <= nmi_request || global_interrupt_enable;
            resume_r     <= (nmi_request || global_interrupt_enable)
                            ? 4'(SRCTL_RESUME_VEC) : 4'(SRCTL_RESUME_NEXT);
        end else if (state_r == SRCTL_WAIT && cnt_done &&
                     !wait_is_reset_r) begin
            resume_vec_r <= global_interrupt_enable;
            resume_r     <= global_interrupt_enable
                            ? 4'(SRCTL_RESUME_VEC) : 4'(SRCTL_RESUME_NEXT);
        end else if (resume_r != 4'h0) begin
            resume_r <= resume_r - 4'h1;
        end
    end

    // ======================================================
    // Core and pin controls
    // ======================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            core_reset        <= 1'b1;
            core_run          <= 1'b0;
            main_osc_enable   <= 1'b1;
            pins_hiz          <= 1'b1;
            port_latch_hold   <= 1'b0;
            load_reset_vector <= 1'b0;
            dispatch_vector   <= 1'b0;
            dispatch_next     <= 1'b0;
        end else begin
            // Contents of stop are kept; only pins float in reset.
            core_reset <= rst_req || state_r == SRCTL_RESET ||
                          (state_r == SRCTL_WAIT && wait_is_reset_r);
            core_run <= !rst_req && state_r == SRCTL_RUN && resume_r == 4'h0;
            main_osc_enable <= !(state_r == SRCTL_STOP && !wake_req);
            pins_hiz <= rst_req || state_r == SRCTL_RESET ||
                        (state_r == SRCTL_WAIT && wait_is_reset_r);
            port_latch_hold <= state_r == SRCTL_STOP ||
                               state_r == SRCTL_HALT;
            load_reset_vector <= !rst_req && state_r == SRCTL_WAIT &&
                                 wait_is_reset_r && cnt_done;
            dispatch_vector <= !rst_req && resume_r == 4'h1 && resume_vec_r;
            dispatch_next   <= !rst_req && resume_r == 4'h1 && !resume_vec_r;
        end
    end

    // Fixed reset vector locations.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_vector_lo_addr <= SRCTL_VEC_LO;
            reset_vector_hi_addr <= SRCTL_VEC_HI;
        end else begin
            reset_vector_lo_addr <= SRCTL_VEC_LO;
            reset_vector_hi_addr <= SRCTL_VEC_HI;
        end
    end

    // ======================================================
    // Peripheral gating in stop and reset
    // ======================================================
    logic stopped;
    assign stopped = (state_r == SRCTL_STOP);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_enable               <= 1'b0;
            adc_enable               <= 1'b0;
            mul_enable               <= 1'b0;
            ext_irq_enable           <= 1'b0;
            event_counter_a_enable   <= 1'b0;
            event_counter_b_enable   <= 1'b0;
            sixteen_bit_timer_enable <= 1'b0;
            eight_bit_timer_c_enable <= 1'b0;
            watch_timer_enable       <= 1'b0;
            serial_enable            <= 1'b0;
            bus_addr_irq_enable      <= 1'b0;
            stab_select_bad          <= 1'b0;
            state_code               <= 3'h0;
        end else begin
            wdt_enable <= !stopped && state_r != SRCTL_RESET;
            adc_enable <= !stopped && state_r != SRCTL_RESET;
            mul_enable <= !stopped && state_r != SRCTL_RESET;
            ext_irq_enable <= state_r != SRCTL_RESET;
            event_counter_a_enable <= !stopped || count_input_a_sel;
            event_counter_b_enable <= !stopped || count_input_b_sel;
            sixteen_bit_timer_enable <= !stopped ||
                (subclk_selected && buzzer_enable);
            eight_bit_timer_c_enable <= !stopped ||
                (subclk_selected && subclk_running);
            watch_timer_enable <= !stopped ||
                (subclk_selected && subclk_running);
            serial_enable <= !stopped || serial_ext_clk;
            bus_addr_irq_enable <= !stopped || bus_slave_mode;
            stab_select_bad <= sel_bad;
            unique case (state_r)
                SRCTL_RESET: state_code <= 3'h0;
                SRCTL_WAIT:  state_code <= 3'h1;
                SRCTL_RUN:   state_code <= 3'h2;
                SRCTL_HALT:  state_code <= 3'h3;
                SRCTL_STOP:  state_code <= 3'h4;
            endcase
        end
    end
endmodule // srctl_top

// *** bench/srctl_env_model.sv ***
`timescale 1ns/100ps
// ==========================================
// External reset source model
// ==========================================
module srctl_env_model #(
    parameter int LOW_CYC = 2000
) (
    input  wire logic clk,
    input  wire logic pull_req,
    output logic      reset_pin_b
);
    int cnt = 0;

    // A request pulls the pin low for the full minimum pulse width.
    always_ff @(posedge clk) begin
        if (pull_req) begin
            cnt <= LOW_CYC;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end

    // The pin is high whenever the source is not pulling it.
    assign reset_pin_b = (cnt == 0);
endmodule // srctl_env_model

// *** bench/srctl_checker.sv ***
`timescale 1ns/100ps
// ==========================================
// Standby and reset sequencing checker
// ==========================================
module srctl_checker #(
    parameter int N_IRQ    = 8,
    parameter int WAIT_RST = 32768
) (
    input wire logic             clk,
    input wire logic             rst_b,
    input wire logic             wdt_overflow,
    input wire logic             stop_instr,
    input wire logic [N_IRQ-1:0] irq_request_flag,
    input wire logic [N_IRQ-1:0] interrupt_mask_flag,
    input wire logic             nmi_request,
    input wire logic             core_reset,
    input wire logic             core_run,
    input wire logic             main_osc_enable,
    input wire logic             pins_hiz,
    input wire logic             port_latch_hold,
    input wire logic             dispatch_vector,
    input wire logic             dispatch_next,
    input wire logic [15:0]      reset_vector_lo_addr,
    input wire logic [15:0]      reset_vector_hi_addr,
    input wire logic             wdt_enable,
    input wire logic             adc_enable,
    input wire logic             mul_enable,
    input wire logic [2:0]       state_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic wake;
    int   stop_cnt;
    int   rst_cnt;

    // An unmasked pending request.
    assign wake = |(irq_request_flag & ~interrupt_mask_flag);

    // Dwell counters: cycles in stop and cycles with core reset high.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_cnt <= 0;
            rst_cnt  <= 0;
        end else begin
            stop_cnt <= (state_code == 3'h4) ? stop_cnt + 1 : 0;
            rst_cnt  <= core_reset ? rst_cnt + 1 : 0;
        end
    end

    a_hiz_in_reset: assert property (core_reset |-> pins_hiz)
        else $error("pins driven during reset");
    a_vector_fixed: assert property (reset_vector_lo_addr == 16'h0000 &&
        reset_vector_hi_addr == 16'h0001) else $error("bad vector address");
    a_stop_quiet: assert property ((state_code == 3'h4 && stop_cnt >= 2
        && !wake) |-> (!main_osc_enable && !core_run && port_latch_hold
        && !wdt_enable && !adc_enable && !mul_enable))
        else $error("activity while stopped");
    a_stop_entry: assert property ((state_code == 3'h2 && core_run
        && stop_instr && !wake && !nmi_request && !wdt_overflow)
        |=> ##1 state_code == 3'h4) else $error("stop not entered");
    a_stop_cause: assert property ((state_code == 3'h4
        && $past(state_code) != 3'h4) |-> $past(stop_instr, 2))
        else $error("stop entered without instruction");
    a_pending_wake: assert property ((state_code == 3'h2 && core_run
        && stop_instr && wake && !wdt_overflow) |=> ##1 state_code == 3'h1)
        else $error("pending request did not release stop");
    a_reset_wait: assert property ($fell(core_reset)
        |-> rst_cnt >= WAIT_RST) else $error("reset wait too short");
    a_wdt_resets: assert property ((wdt_overflow && !core_reset)
        |-> ##[1:3] core_reset) else $error("watchdog reset missing");

    c_stopped: cover property (state_code == 3'h4 && stop_cnt == 3);
    c_vector: cover property (dispatch_vector);
    c_next: cover property (dispatch_next);
endmodule // srctl_checker

bind srctl_top srctl_checker #(.N_IRQ(N_IRQ), .WAIT_RST(WAIT_RST))
    u_srctl_checker (.clk, .rst_b, .wdt_overflow, .stop_instr,
    .irq_request_flag, .interrupt_mask_flag, .nmi_request, .core_reset,
    .core_run, .main_osc_enable, .pins_hiz, .port_latch_hold,
    .dispatch_vector, .dispatch_next, .reset_vector_lo_addr,
    .reset_vector_hi_addr, .wdt_enable, .adc_enable, .mul_enable,
    .state_code);

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
// ==========================================
// Standby and reset sequencing testbench
// ==========================================
module tb_top;
    import srctl_pkg::*;
    localparam int WR = 32;
    localparam int WT [3] = '{16, 32, 64};
    localparam logic [2:0] SEL [3] = '{3'h0, 3'h2, 3'h4};
    logic clk = 1'b0, rst_b = 1'b0, reset_pin_b, pull_req = 1'b0;
    logic wdt_overflow = 1'b0, halt_instr = 1'b0, stop_instr = 1'b0;
    logic nmi_request = 1'b0, global_interrupt_enable = 1'b0;
    logic count_input_a_sel = 1'b0, count_input_b_sel = 1'b0;
    logic subclk_selected = 1'b0, subclk_running = 1'b0;
    logic buzzer_enable = 1'b0, serial_ext_clk = 1'b0, bus_slave_mode = 1'b0;
    logic [7:0] irq_request_flag = 8'h00, interrupt_mask_flag = 8'hff;
    logic [2:0] stab_time_select = 3'h4, state_code;
    logic [15:0] reset_vector_lo_addr, reset_vector_hi_addr;
    logic core_reset, core_run, main_osc_enable, pins_hiz, port_latch_hold;
    logic dispatch_vector, dispatch_next, load_reset_vector, wdt_enable;
    logic adc_enable, mul_enable, ext_irq_enable, event_counter_a_enable;
    logic event_counter_b_enable, sixteen_bit_timer_enable, serial_enable;
    logic eight_bit_timer_c_enable, watch_timer_enable, bus_addr_irq_enable;
    logic stab_select_bad, saw_vec, saw_load;
    int num_errors = 0, checks_done = 0, n;

    srctl_top #(.WAIT_RST(WR), .WAIT_12(WT[0]), .WAIT_15(WT[1]),
        .WAIT_17(WT[2])) u_srctl_top (.clk, .rst_b, .reset_pin_b,
        .wdt_overflow, .halt_instr, .stop_instr, .irq_request_flag,
        .interrupt_mask_flag, .nmi_request, .global_interrupt_enable,
        .stab_time_select, .count_input_a_sel, .count_input_b_sel,
        .subclk_selected, .subclk_running, .buzzer_enable, .serial_ext_clk,
        .bus_slave_mode, .core_reset, .core_run, .main_osc_enable, .pins_hiz,
        .port_latch_hold, .dispatch_vector, .dispatch_next,
        .load_reset_vector, .reset_vector_lo_addr, .reset_vector_hi_addr,
        .wdt_enable, .adc_enable, .mul_enable, .ext_irq_enable,
        .event_counter_a_enable, .event_counter_b_enable,
        .sixteen_bit_timer_enable, .eight_bit_timer_c_enable,
        .watch_timer_enable, .serial_enable, .bus_addr_irq_enable,
        .stab_select_bad, .state_code);
    srctl_env_model #(.LOW_CYC(SRCTL_RST_MIN_CYC)) u_srctl_env_model (.clk,
        .pull_req, .reset_pin_b);

    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Compares a seen value against its expectation.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Counts settled cycles until a dispatch pulse (d) or a running core.
    task automatic wait_for(input logic d);
        n = 0;
        saw_load = 1'b0;
        while ((d ? dispatch_vector | dispatch_next : core_run) !== 1'b1
               && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
            saw_load |= (load_reset_vector === 1'b1);
        end
        saw_vec = dispatch_vector;
    endtask

    // Waits for a running core, then pulses one standby instruction.
    task automatic issue(input logic stop);
        wait_for(1'b0);
        @(posedge clk);
        stop_instr <= stop;
        halt_instr <= !stop;
        @(posedge clk);
        stop_instr <= 1'b0;
        halt_instr <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Hang guard.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wait_for(1'b0);
        check(n >= WR && n <= WR + 14, 1'b1);
        check({saw_load, pins_hiz}, 2'h2);
        check({reset_vector_hi_addr, reset_vector_lo_addr}, 32'h10000);
        $display("Test power-on reset done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            stab_time_select <= SEL[i];
            {count_input_a_sel, count_input_b_sel} <= {i[0], !i[0]};
            {subclk_selected, subclk_running} <= {i != 1, i == 0};
            {buzzer_enable, serial_ext_clk} <= {i != 0, i != 1};
            bus_slave_mode <= i[0];
            global_interrupt_enable <= (i != 1);
            irq_request_flag[0] <= 1'b1;
            issue(1'b1);
            check(state_code, 3'h4);
            check({main_osc_enable, core_run, port_latch_hold}, 3'h1);
            check({wdt_enable, adc_enable, mul_enable, ext_irq_enable},
                  4'h1);
            check({event_counter_a_enable, event_counter_b_enable},
                  {i[0], !i[0]});
            check({sixteen_bit_timer_enable, eight_bit_timer_c_enable,
                   watch_timer_enable}, {i == 2, i == 0, i == 0});
            check(serial_enable, i != 1);
            check(bus_addr_irq_enable, i[0]);
            @(posedge clk);
            interrupt_mask_flag[0] <= 1'b0;
            wait_for(1'b1);
            check(n >= WT[i] && n <= WT[i] + 14, 1'b1);
            check(saw_vec, i != 1);
            @(posedge clk);
            {irq_request_flag[0], interrupt_mask_flag[0]} <= 2'b01;
        end
        $display("Test stop wake done");
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            global_interrupt_enable <= e[0];
            irq_request_flag[1] <= 1'b1;
            issue(1'b0);
            check(state_code, 3'h3);
            @(posedge clk);
            interrupt_mask_flag[1] <= 1'b0;
            wait_for(1'b1);
            check(saw_vec, e[0]);
            check(e ? n >= 9 && n <= 12 : n >= 1 && n <= 4, 1'b1);
            @(posedge clk);
            {irq_request_flag[1], interrupt_mask_flag[1]} <= 2'b01;
        end
        issue(1'b0);
        @(posedge clk);
        nmi_request <= 1'b1;
        wait_for(1'b1);
        check(saw_vec, 1'b1);
        @(posedge clk);
        nmi_request <= 1'b0;
        stab_time_select <= 3'h1;
        {irq_request_flag[2], interrupt_mask_flag[2]} <= 2'b10;
        $display("Test halt wake done");
        issue(1'b1);
        check({stab_select_bad, state_code}, 4'h9);
        wait_for(1'b1);
        check(n >= WT[2] - 6 && n <= WT[2] + 14, 1'b1);
        check(saw_vec, global_interrupt_enable);
        @(posedge clk);
        {irq_request_flag[2], interrupt_mask_flag[2]} <= 2'b01;
        issue(1'b1);
        @(posedge clk);
        pull_req <= 1'b1;
        @(posedge clk);
        pull_req <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
        check({core_reset, pins_hiz}, 2'h3);
        while (reset_pin_b !== 1'b1) @(posedge clk);
        wait_for(1'b0);
        check(n >= WR && n <= WR + 14, 1'b1);
        check(saw_load, 1'b1);
        issue(1'b0);
        @(posedge clk);
        wdt_overflow <= 1'b1;
        @(posedge clk);
        wdt_overflow <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(core_reset, 1'b1);
        wait_for(1'b0);
        check(n >= WR - 4 && n <= WR + 14, 1'b1);
        check(saw_load, 1'b1);
        $display("Test reset sources done");
        tally_and_finish();
    end
endmodule // tb_top
